// ==== src/hsi_pkg.sv ====
// package: constants and types for the modem host serial interface
package hsi_pkg;
	localparam int CLK_HZ       = 10_000_000;
	localparam int LINK_HZ      = 66_666_667;
	localparam int ACK_HOLD_MS  = 25;
	localparam int ACK_WIN_MS   = 250;
	localparam int ACK_HOLD_CYC = CLK_HZ / 1000 * ACK_HOLD_MS;
	localparam int ACK_WIN_CYC  = CLK_HZ / 1000 * ACK_WIN_MS;
	localparam int ACK_W        = 22;
	localparam int AB_LO_BPS    = 300;
	localparam int AB_HI_BPS    = 9600;
	localparam int TOL_FAST_PM  = 10;
	localparam int TOL_SLOW_PM  = 25;
	localparam int AB_MIN_CYC   = LINK_HZ / AB_HI_BPS * (1000 - TOL_FAST_PM) / 1000;
	localparam int AB_MAX_CYC   = LINK_HZ / AB_LO_BPS * (1000 + TOL_SLOW_PM) / 1000;
	localparam int SYNC_BPS     = 2400;
	localparam int SYNC_HALF_CYC = LINK_HZ / SYNC_BPS / 2;
	localparam int BIT_W        = 18;
	localparam int DATA_W       = 8;
	localparam int FIFO_DEPTH   = 32;
	localparam int ASYNC_BITS   = 10;
	typedef enum logic [1:0] {DTR_NONE = 2'h0, DTR_REQ = 2'h1, DTR_PWRDN = 2'h2} hsi_dtr_fn_e;
	typedef enum logic [1:0] {PS_RUN = 2'h1, PS_STBY = 2'h2} hsi_pwr_e;
	typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8} hsi_rx_e;
	typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SHIFT = 2'h2} hsi_tx_e;
endpackage : hsi_pkg

// ==== src/hsi_fifo.sv ====
// module: synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module hsi_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [AW:0]   cnt, next_cnt;
	logic          push, pop;

	assign in_ready_o  = (cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt != '0);
	assign out_data_o  = mem[rp];

	always_comb begin
		push     = in_valid_i & in_ready_o;
		pop      = out_valid_o & out_ready_i;
		next_wp  = push ? wp + 1'b1 : wp;
		next_rp  = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= in_data_i;
		end
		if (rst_i) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			wp  <= next_wp;
			rp  <= next_rp;
			cnt <= next_cnt;
		end
	end
endmodule : hsi_fifo
`default_nettype wire

// ==== src/hsi_top.sv ====
// module: host-facing serial port, handshake lines and standby control
// Function
// - with standby enabled, the modem idle and no character queued for the link or left unread, the device drops into standby by itself.
// - in standby the serial, timer and interrupt logic keep running while the core clock stops.
// - standby ends on data-terminal-ready, ring, an arriving character or reset.
// - each character from the host raises an internal character interrupt.
// - terminal-ready and ring are interrupt sources, and ring indication goes active with each ring message.
// - a terminal-ready assertion requests a configurable function, one choice being power-down.
// - after reset carrier-detect, clear-to-send and set-ready stay inactive 25 ms within a 250 ms window.
// - serial data moves least significant bit first in both modes.
// - asynchronous characters move at the chosen rate within +1 % and -2.5 %.
// - the asynchronous rate is learned automatically between 300 and 9600 bps.
// - synchronous mode drives both serial clocks and gives request/clear-to-send flow control.
// - the hook relay output follows firmware control.
// - synchronous data is valid at the rising edge of its serial clock.
`timescale 1ns/1ns
`default_nettype none
module hsi_top #(
	parameter int ACK_HOLD_CYC  = hsi_pkg::ACK_HOLD_CYC,
	parameter int ACK_WIN_CYC   = hsi_pkg::ACK_WIN_CYC,
	parameter int AB_MIN_CYC    = hsi_pkg::AB_MIN_CYC,
	parameter int AB_MAX_CYC    = hsi_pkg::AB_MAX_CYC,
	parameter int SYNC_HALF_CYC = hsi_pkg::SYNC_HALF_CYC
) (
	// clocks and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       link_clk_i,
	// host serial pins
	input  wire logic       txd_i,
	output logic            rxd_o,
	output logic            tx_sync_clock_out_o,
	output logic            rx_sync_clock_out_o,
	// host handshake pins
	input  wire logic       rts_n_i,
	input  wire logic       dtr_n_i,
	input  wire logic       ring_n_i,
	output logic            cts_n_o,
	output logic            dsr_n_o,
	output logic            dcd_n_o,
	output logic            ri_n_o,
	output logic            relay_o,
	// firmware control
	input  wire logic       sync_mode_i,
	input  wire logic       stby_en_i,
	input  wire logic       modem_idle_i,
	input  wire logic       carrier_i,
	input  wire logic       hook_i,
	input  wire logic       ring_msg_i,
	input  wire logic [1:0] dtr_fn_i,
	// data to host
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_valid_i,
	output logic            wr_ready_o,
	// data from host
	output logic [7:0]      char_data_o,
	output logic            char_valid_o,
	input  wire logic       char_ready_i,
	// events and status
	output logic            int_char_o,
	output logic            int_dtr_o,
	output logic            int_ring_o,
	output logic            dtr_req_o,
	output logic            pwr_down_req_o,
	output logic            core_run_o,
	output logic            ready_o
);
	localparam int AW = hsi_pkg::ACK_W;
	localparam int BW = hsi_pkg::BIT_W;
	localparam logic [AW-1:0] HOLD_C = AW'(ACK_HOLD_CYC);
	localparam logic [AW-1:0] WIN_C  = AW'(ACK_WIN_CYC);
	localparam logic [BW-1:0] ABMN_C = BW'(AB_MIN_CYC);
	localparam logic [BW-1:0] ABMX_C = BW'(AB_MAX_CYC);
	localparam logic [BW-1:0] SHLF_C = BW'(SYNC_HALF_CYC);

	function automatic logic [BW-1:0] half(input logic [BW-1:0] v);
		return {1'b0, v[BW-1:1]};
	endfunction : half

	function automatic logic rate_ok(input logic [BW-1:0] v);
		return (v >= ABMN_C) && (v < ABMX_C);
	endfunction : rate_ok

	// ---------------- core domain ----------------
	logic [4:0] cs1, cs2;
	logic       rx_seen, dtr_q, ring_q;
	logic       dtr_act, ring_act, rts_act, rx_ev, pend;
	logic       fifo_ov, fifo_rd;
	logic [7:0] fifo_od;
	hsi_pkg::hsi_pwr_e pwr, next_pwr;
	logic [AW-1:0] ack, next_ack;
	logic       tx_req, next_tx_req;
	logic [7:0] tx_hold, next_tx_hold, next_char_data;
	logic       next_char_valid, next_cts_n, next_dsr_n, next_dcd_n;
	logic       next_int_dtr, next_int_ring, next_dtr_req, next_pd_req;
	logic       ack_done;
	logic       rx_tgl, tx_ack;
	logic [7:0] rx_byte;

	assign dtr_act  = cs2[4];
	assign ring_act = cs2[3];
	assign rts_act  = cs2[2];
	assign rx_ev    = cs2[1] ^ rx_seen;
	assign pend     = tx_req ^ cs2[0];
	assign fifo_rd  = fifo_ov & ~pend;
	assign ack_done = (ack >= HOLD_C);
	assign core_run_o = (pwr == hsi_pkg::PS_RUN);

	// fills while the host holds rts off; wr_ready_o carries the stall back
	hsi_fifo #(.W(hsi_pkg::DATA_W), .DEPTH(hsi_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (sys_rst_i),
		.in_valid_i  (wr_valid_i),
		.in_data_i   (wr_data_i),
		.in_ready_o  (wr_ready_o),
		.out_valid_o (fifo_ov),
		.out_data_o  (fifo_od),
		.out_ready_i (fifo_rd)
	);

	always_comb begin
		next_pwr = pwr;
		case (pwr)
			hsi_pkg::PS_RUN: begin
				if (stby_en_i && modem_idle_i && !fifo_ov && !pend && !char_valid_o) begin
					next_pwr = hsi_pkg::PS_STBY;
				end
			end
			hsi_pkg::PS_STBY: begin
				if (dtr_act || ring_act || rx_ev) begin
					next_pwr = hsi_pkg::PS_RUN;
				end
			end
			default: next_pwr = hsi_pkg::PS_RUN;
		endcase
		next_ack        = (ack != WIN_C) ? ack + 1'b1 : ack;
		next_tx_req     = fifo_rd ? ~tx_req : tx_req;
		next_tx_hold    = fifo_rd ? fifo_od : tx_hold;
		next_char_data  = rx_ev ? rx_byte : char_data_o;
		next_char_valid = rx_ev | (char_valid_o & ~char_ready_i);
		// host must not send while cts is off; overrun simply overwrites
		next_cts_n      = ~(ack_done & rts_act & ~next_char_valid);
		next_dsr_n      = ~ack_done;
		next_dcd_n      = ~(ack_done & carrier_i);
		next_int_dtr    = dtr_act & ~dtr_q;
		next_int_ring   = ring_act & ~ring_q;
		next_dtr_req    = next_int_dtr && (dtr_fn_i == hsi_pkg::DTR_REQ);
		next_pd_req     = next_int_dtr && (dtr_fn_i == hsi_pkg::DTR_PWRDN);
	end

	always_ff @(posedge clk_i) begin
		cs1 <= {~dtr_n_i, ~ring_n_i, ~rts_n_i, rx_tgl, tx_ack};
		cs2 <= cs1;
		if (sys_rst_i) begin
			pwr            <= hsi_pkg::PS_RUN;
			ack            <= '0;
			rx_seen        <= 1'b0;
			dtr_q          <= 1'b0;
			ring_q         <= 1'b0;
			tx_req         <= 1'b0;
			tx_hold        <= 8'h00;
			char_data_o    <= 8'h00;
			char_valid_o   <= 1'b0;
			cts_n_o        <= 1'b1;
			dsr_n_o        <= 1'b1;
			dcd_n_o        <= 1'b1;
			ri_n_o         <= 1'b1;
			relay_o        <= 1'b0;
			int_char_o     <= 1'b0;
			int_dtr_o      <= 1'b0;
			int_ring_o     <= 1'b0;
			dtr_req_o      <= 1'b0;
			pwr_down_req_o <= 1'b0;
			ready_o        <= 1'b0;
		end else begin
			pwr            <= next_pwr;
			ack            <= next_ack;
			rx_seen        <= cs2[1];
			dtr_q          <= dtr_act;
			ring_q         <= ring_act;
			tx_req         <= next_tx_req;
			tx_hold        <= next_tx_hold;
			char_data_o    <= next_char_data;
			char_valid_o   <= next_char_valid;
			cts_n_o        <= next_cts_n;
			dsr_n_o        <= next_dsr_n;
			dcd_n_o        <= next_dcd_n;
			ri_n_o         <= ~ring_msg_i;
			relay_o        <= hook_i;
			int_char_o     <= rx_ev;
			int_dtr_o      <= next_int_dtr;
			int_ring_o     <= next_int_ring;
			dtr_req_o      <= next_dtr_req;
			pwr_down_req_o <= next_pd_req;
			ready_o        <= (next_ack == WIN_C);
		end
	end

	// ---------------- link domain: runs in standby too ----------------
	logic [4:0] ls1, ls2;
	logic       link_rst, l_txd, l_rts, l_sync, l_req;
	hsi_pkg::hsi_rx_e rx_st, next_rx_st;
	hsi_pkg::hsi_tx_e tx_st, next_tx_st;
	logic [BW-1:0] rx_cnt, next_rx_cnt, bit_per, next_bit_per, tx_cnt, next_tx_cnt, s_cnt, next_s_cnt;
	logic [3:0] rx_bits, next_rx_bits, tx_bits, next_tx_bits;
	logic [7:0] rx_sh, next_rx_sh, next_rx_byte;
	logic [9:0] tx_sh, next_tx_sh;
	logic       locked, next_locked, next_rx_tgl, next_tx_ack, next_txo, sclk, next_sclk;
	logic       s_tick, s_rise, s_fall, tx_tick;

	assign link_rst = ls2[4];
	assign l_txd    = ls2[3];
	assign l_rts    = ls2[2];
	assign l_sync   = ls2[1];
	assign l_req    = ls2[0];
	assign s_tick   = l_sync && (s_cnt == '0);
	assign s_rise   = s_tick & ~sclk;
	assign s_fall   = s_tick & sclk;
	assign tx_tick  = l_sync ? s_fall : (tx_cnt == '0);
	assign tx_sync_clock_out_o = sclk;
	assign rx_sync_clock_out_o = sclk;

	always_comb begin
		next_s_cnt   = l_sync ? (s_tick ? SHLF_C - 1'b1 : s_cnt - 1'b1) : '0;
		next_sclk    = l_sync & (sclk ^ s_tick);
		next_rx_st   = rx_st;
		next_rx_cnt  = rx_cnt;
		next_rx_bits = rx_bits;
		next_rx_sh   = rx_sh;
		next_rx_byte = rx_byte;
		next_rx_tgl  = rx_tgl;
		next_bit_per = bit_per;
		next_locked  = locked;
		if (l_sync) begin
			if (s_rise) begin
				next_rx_sh   = {l_txd, rx_sh[7:1]};
				next_rx_bits = (rx_bits == 4'h7) ? 4'h0 : rx_bits + 4'h1;
				if (rx_bits == 4'h7) begin
					next_rx_byte = next_rx_sh;
					next_rx_tgl  = ~rx_tgl;
				end
			end
		end else begin
			case (rx_st)
				hsi_pkg::RX_IDLE: begin
					if (!l_txd) begin
						next_rx_st  = hsi_pkg::RX_START;
						next_rx_cnt = locked ? half(bit_per) : '0;
					end
				end
				hsi_pkg::RX_START: begin
					if (locked) begin
						if (rx_cnt != '0) begin
							next_rx_cnt = rx_cnt - 1'b1;
						end else if (l_txd) begin
							next_rx_st = hsi_pkg::RX_IDLE;
						end else begin
							next_rx_st   = hsi_pkg::RX_DATA;
							next_rx_cnt  = bit_per;
							next_rx_bits = 4'h0;
						end
					end else if (l_txd) begin
						// start bit length is the bit time
						if (rate_ok(rx_cnt)) begin
							next_bit_per = rx_cnt;
							next_locked  = 1'b1;
							next_rx_st   = hsi_pkg::RX_DATA;
							next_rx_cnt  = half(rx_cnt);
							next_rx_bits = 4'h0;
						end else begin
							next_rx_st = hsi_pkg::RX_IDLE;
						end
					end else if (rx_cnt < ABMX_C) begin
						next_rx_cnt = rx_cnt + 1'b1;
					end
				end
				hsi_pkg::RX_DATA: begin
					if (rx_cnt != '0) begin
						next_rx_cnt = rx_cnt - 1'b1;
					end else begin
						next_rx_sh   = {l_txd, rx_sh[7:1]};
						next_rx_cnt  = bit_per;
						next_rx_bits = rx_bits + 4'h1;
						if (rx_bits == 4'h7) begin
							next_rx_st = hsi_pkg::RX_STOP;
						end
					end
				end
				hsi_pkg::RX_STOP: begin
					if (rx_cnt != '0) begin
						next_rx_cnt = rx_cnt - 1'b1;
					end else begin
						next_rx_st = hsi_pkg::RX_IDLE;
						if (l_txd) begin
							next_rx_byte = rx_sh;
							next_rx_tgl  = ~rx_tgl;
						end else begin
							next_locked = 1'b0; // framing loss: relearn the rate
						end
					end
				end
				default: next_rx_st = hsi_pkg::RX_IDLE;
			endcase
		end
		next_tx_st   = tx_st;
		next_tx_cnt  = tx_cnt;
		next_tx_bits = tx_bits;
		next_tx_sh   = tx_sh;
		next_tx_ack  = tx_ack;
		next_txo     = rxd_o;
		case (tx_st)
			hsi_pkg::TX_IDLE: begin
				// async sends wait for a learned rate
				if ((l_req != tx_ack) && l_rts && (l_sync ? s_fall : locked)) begin
					next_tx_ack  = ~tx_ack;
					next_tx_st   = hsi_pkg::TX_SHIFT;
					next_tx_cnt  = bit_per;
					next_txo     = l_sync ? tx_hold[0] : 1'b0;
					next_tx_sh   = l_sync ? {3'h7, tx_hold[7:1]} : {1'b1, 1'b1, tx_hold};
					next_tx_bits = l_sync ? 4'h7 : 4'(hsi_pkg::ASYNC_BITS - 1);
				end
			end
			hsi_pkg::TX_SHIFT: begin
				if (!tx_tick) begin
					next_tx_cnt = tx_cnt - 1'b1;
				end else if (tx_bits == 4'h0) begin
					next_txo   = 1'b1;
					next_tx_st = hsi_pkg::TX_IDLE;
				end else begin
					next_txo     = tx_sh[0];
					next_tx_sh   = {1'b1, tx_sh[9:1]};
					next_tx_bits = tx_bits - 4'h1;
					next_tx_cnt  = bit_per;
				end
			end
			default: next_tx_st = hsi_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge link_clk_i) begin
		ls1 <= {sys_rst_i, txd_i, ~rts_n_i, sync_mode_i, tx_req};
		ls2 <= ls1;
		if (link_rst) begin
			s_cnt   <= '0;
			sclk    <= 1'b0;
			rx_st   <= hsi_pkg::RX_IDLE;
			rx_cnt  <= '0;
			rx_bits <= 4'h0;
			rx_sh   <= 8'h00;
			rx_byte <= 8'h00;
			rx_tgl  <= 1'b0;
			bit_per <= '0;
			locked  <= 1'b0;
			tx_st   <= hsi_pkg::TX_IDLE;
			tx_cnt  <= '0;
			tx_bits <= 4'h0;
			tx_sh   <= 10'h3ff;
			tx_ack  <= 1'b0;
			rxd_o   <= 1'b1;
		end else begin
			s_cnt   <= next_s_cnt;
			sclk    <= next_sclk;
			rx_st   <= next_rx_st;
			rx_cnt  <= next_rx_cnt;
			rx_bits <= next_rx_bits;
			rx_sh   <= next_rx_sh;
			rx_byte <= next_rx_byte;
			rx_tgl  <= next_rx_tgl;
			bit_per <= next_bit_per;
			locked  <= next_locked;
			tx_st   <= next_tx_st;
			tx_cnt  <= next_tx_cnt;
			tx_bits <= next_tx_bits;
			tx_sh   <= next_tx_sh;
			tx_ack  <= next_tx_ack;
			rxd_o   <= next_txo;
		end
	end

	// ---------------- checks ----------------
	a_stby_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pwr == hsi_pkg::PS_RUN && stby_en_i && modem_idle_i && !fifo_ov && !pend && !char_valid_o
		|=> !core_run_o) else $error("standby not entered when idle");
	a_stby_serial: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!core_run_o && rx_ev |=> int_char_o && core_run_o) else $error("serial path stalled in standby");
	a_wake_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!core_run_o && (dtr_act || ring_act) |=> core_run_o) else $error("no wake on dtr or ring");
	a_char_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rx_ev |=> int_char_o && char_valid_o ##1 !int_char_o) else $error("character interrupt wrong");
	a_dtr_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(dtr_act) |=> int_dtr_o ##1 !int_dtr_o) else $error("dtr interrupt wrong");
	a_ring_ind: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ring_msg_i |=> !ri_n_o) else $error("ring indication missing");
	a_pwrdn_req: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(dtr_act) && dtr_fn_i == hsi_pkg::DTR_PWRDN |=> pwr_down_req_o && !dtr_req_o)
		else $error("power-down request wrong");
	a_ack_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ack < HOLD_C |-> cts_n_o && dsr_n_o && dcd_n_o) else $error("handshake active in reset hold");
	a_ack_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ack == HOLD_C |=> !dsr_n_o) else $error("set-ready not released after hold");
	a_cts_flow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!rts_act |=> cts_n_o) else $error("cts active without rts");
	a_relay_ctl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		hook_i != relay_o |=> relay_o == $past(hook_i)) else $error("relay not following control");
	a_rate_range: assert property (@(posedge link_clk_i) disable iff (link_rst)
		locked |-> rate_ok(bit_per)) else $error("locked rate out of range");
	a_sync_launch: assert property (@(posedge link_clk_i) disable iff (link_rst)
		l_sync && $stable(l_sync) && $changed(rxd_o) |-> !sclk && $past(sclk))
		else $error("sync data changed off the falling edge");
	c_standby: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(core_run_o));
	c_char_wake: cover property (@(posedge clk_i) disable iff (sys_rst_i) !core_run_o && rx_ev);
	c_fifo_full: cover property (@(posedge clk_i) disable iff (sys_rst_i) !wr_ready_o);
	c_rate_lock: cover property (@(posedge link_clk_i) disable iff (link_rst) $rose(locked));
endmodule : hsi_top
`default_nettype wire

// ==== bench/hsi_host_model.sv ====
// host terminal model: asynchronous character sender and receiver on the link clock
`timescale 1ns/1ns
`default_nettype none
module hsi_host_model #(
	parameter int BIT_CYC = 40
) (
	// link clock
	input  wire logic link_clk_i,
	// link pins
	input  wire logic rxd_i,
	input  wire logic cts_n_i,
	output logic      txd_o
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	// line idles high between characters
	initial txd_o = 1'b1;

	// start bit, eight data bits lsb first, stop bit
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		wait (cts_n_i === 1'b0);
		for (int i = 0; i < 10; i++) begin
			@(posedge link_clk_i);
			txd_o <= fr[i];
			repeat (BIT_CYC - 1) @(posedge link_clk_i);
		end
	endtask : send

	// mid-bit sampling leaves margin for a learned rate a few cycles off
	initial begin
		forever begin
			@(negedge rxd_i);
			repeat (BIT_CYC / 2) @(posedge link_clk_i);
			if (rxd_i === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYC) @(posedge link_clk_i);
					sh[i] = rxd_i;
				end
				rx_q.push_back(sh);
				repeat (BIT_CYC) @(posedge link_clk_i);
			end
		end
	end
endmodule : hsi_host_model
`default_nettype wire

// ==== bench/modem_host_serial_interface_test.sv ====
// self-checking bench for the host serial interface
`timescale 1ns/1ns
`default_nettype none
module modem_host_serial_interface_test;
	localparam int HOLD = 20;
	localparam int WIN  = 200;
	localparam int HALF = 8;
	localparam int BITC = 40;

	logic       clk_i, link_clk_i, sys_rst_i, txd_i, rts_n_i, dtr_n_i, ring_n_i;
	logic       rxd_o, tx_sync_clock_out_o, rx_sync_clock_out_o, cts_n_o, dsr_n_o, dcd_n_o, ri_n_o, relay_o;
	logic       sync_mode_i, stby_en_i, modem_idle_i, carrier_i, hook_i, ring_msg_i;
	logic [1:0] dtr_fn_i;
	logic [7:0] wr_data_i, char_data_o;
	logic       wr_valid_i, wr_ready_o, char_valid_o, char_ready_i;
	logic       int_char_o, int_dtr_o, int_ring_o, dtr_req_o, pwr_down_req_o, core_run_o, ready_o;
	logic       pv, pr;
	logic [7:0] got_q[$];
	int         fail_count = 0, total_checks = 0;
	int         n_char = 0, n_dtr = 0, n_ring = 0, n_req = 0, n_pwr = 0;

	hsi_top #(.ACK_HOLD_CYC(HOLD), .ACK_WIN_CYC(WIN), .AB_MIN_CYC(20), .AB_MAX_CYC(2000),
		.SYNC_HALF_CYC(HALF)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
		.txd_i(txd_i), .rxd_o(rxd_o), .tx_sync_clock_out_o(tx_sync_clock_out_o),
		.rx_sync_clock_out_o(rx_sync_clock_out_o), .rts_n_i(rts_n_i), .dtr_n_i(dtr_n_i), .ring_n_i(ring_n_i),
		.cts_n_o(cts_n_o), .dsr_n_o(dsr_n_o), .dcd_n_o(dcd_n_o), .ri_n_o(ri_n_o), .relay_o(relay_o),
		.sync_mode_i(sync_mode_i), .stby_en_i(stby_en_i), .modem_idle_i(modem_idle_i), .carrier_i(carrier_i),
		.hook_i(hook_i), .ring_msg_i(ring_msg_i), .dtr_fn_i(dtr_fn_i), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .char_data_o(char_data_o),
		.char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .int_char_o(int_char_o),
		.int_dtr_o(int_dtr_o), .int_ring_o(int_ring_o), .dtr_req_o(dtr_req_o),
		.pwr_down_req_o(pwr_down_req_o), .core_run_o(core_run_o), .ready_o(ready_o));

	hsi_host_model #(.BIT_CYC(BITC)) host (.link_clk_i(link_clk_i), .rxd_i(rxd_o), .cts_n_i(cts_n_o),
		.txd_o(txd_i));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// 15 ns link clock, phase unrelated to the core clock
	initial begin
		link_clk_i = 1'b0;
		#3;
		forever begin
			#7 link_clk_i = 1'b1;
			#8 link_clk_i = 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (int_char_o === 1'b1) n_char++;
		if (int_dtr_o === 1'b1) n_dtr++;
		if (int_ring_o === 1'b1) n_ring++;
		if (dtr_req_o === 1'b1) n_req++;
		if (pwr_down_req_o === 1'b1) n_pwr++;
		if (char_valid_o === 1'b1 && char_ready_i) got_q.push_back(char_data_o);
	end

	function automatic int exp_rises(input int span);
		return span / (2 * HALF);
	endfunction : exp_rises

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic reset_dut();
		sys_rst_i = 1'b1;
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
	endtask : reset_dut

	task automatic tally_and_finish();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (40000) @(posedge clk_i);
		fail_count++;
		$display("ERROR watchdog expected finish seen timeout");
		tally_and_finish();
	end

	initial begin
		logic [7:0] b;
		logic [7:0] sent_q[$];
		int         acc, d0, r0, p0, g0;
		{sys_rst_i, rts_n_i, dtr_n_i, ring_n_i, sync_mode_i, stby_en_i, modem_idle_i} = 7'h58;
		{carrier_i, hook_i, ring_msg_i, dtr_fn_i, wr_data_i, wr_valid_i, char_ready_i} = 15'h4001;
		void'($urandom(32'he713));
		reset_dut();
		for (int i = 0; i < HOLD; i++) begin
			@(negedge clk_i);
			chk("ack lines held", 3'h7, {cts_n_o, dsr_n_o, dcd_n_o});
		end
		@(negedge clk_i);
		chk("set ready after hold", 0, dsr_n_o);
		repeat (WIN - HOLD - 3) @(negedge clk_i);
		chk("ready before window", 0, ready_o);
		repeat (3) @(negedge clk_i);
		chk("ready after window", 1, ready_o);
		chk("ack lines active", 3'h0, {cts_n_o, dsr_n_o, dcd_n_o});
		chk("sync clock low in async", 0, tx_sync_clock_out_o);
		// first character teaches the rate, so its start bit stands alone
		for (int k = 0; k < 6; k++) begin
			b = 8'($urandom);
			if (k == 0) b[0] = 1'b1;
			sent_q.push_back(b);
			host.send(b);
		end
		repeat (20) @(negedge clk_i);
		chk("chars seen", 6, got_q.size());
		chk("char interrupts", 6, n_char);
		foreach (sent_q[i]) chk("char data", sent_q[i], got_q[i]);
		// fill with request-to-send off, then let it drain
		host.rx_q.delete();
		sent_q.delete();
		acc = 0;
		@(negedge clk_i);
		rts_n_i = 1'b1;
		repeat (40) begin
			@(negedge clk_i);
			b = 8'($urandom);
			if (wr_ready_o === 1'b1) begin
				acc++;
				sent_q.push_back(b);
			end
			wr_valid_i = 1'b1;
			wr_data_i = b;
		end
		@(negedge clk_i);
		wr_valid_i = 1'b0;
		// fifo plus at most two holding stages toward the link
		chk("fill refused near depth", 1, acc >= 32 && acc <= 34);
		rts_n_i = 1'b0;
		for (int i = 0; i < 4000 && host.rx_q.size() < acc; i++) @(negedge clk_i);
		chk("drained count", acc, host.rx_q.size());
		foreach (sent_q[i]) chk("sent data", sent_q[i], host.rx_q[i]);
		d0 = n_dtr;
		r0 = n_req;
		p0 = n_pwr;
		g0 = n_ring;
		for (int f = 0; f < 3; f++) begin
			dtr_fn_i = 2'(f);
			dtr_n_i = 1'b0;
			repeat (10) @(negedge clk_i);
			dtr_n_i = 1'b1;
			repeat (10) @(negedge clk_i);
		end
		ring_n_i = 1'b0;
		repeat (10) @(negedge clk_i);
		ring_n_i = 1'b1;
		repeat (10) @(negedge clk_i);
		chk("dtr interrupts", d0 + 3, n_dtr);
		chk("dtr request", r0 + 1, n_req);
		chk("power down request", p0 + 1, n_pwr);
		chk("ring interrupts", g0 + 1, n_ring);
		repeat (6) begin
			hook_i = 1'($urandom);
			ring_msg_i = 1'($urandom);
			@(negedge clk_i);
			chk("relay follows hook", hook_i, relay_o);
			chk("ring indicator", !ring_msg_i, ri_n_o);
		end
		// wake by terminal-ready, ring and an arriving character
		for (int k = 0; k < 3; k++) begin
			stby_en_i = 1'b1;
			modem_idle_i = 1'b1;
			for (int i = 0; i < 20 && core_run_o !== 1'b0; i++) @(negedge clk_i);
			chk("standby entered", 0, core_run_o);
			if (k == 0) dtr_n_i = 1'b0;
			else if (k == 1) ring_n_i = 1'b0;
			else begin
				// sent alongside so standby is cleared the cycle the wake is seen
				fork
					host.send(8'h5a);
				join_none
			end
			for (int i = 0; i < 200 && core_run_o !== 1'b1; i++) @(negedge clk_i);
			chk("standby left", 1, core_run_o);
			stby_en_i = 1'b0;
			{dtr_n_i, ring_n_i} = 2'h3;
			repeat (10) @(negedge clk_i);
		end
		chk("char taken in standby", 8'h5a, got_q[got_q.size() - 1]);
		sync_mode_i = 1'b1;
		reset_dut();
		repeat (5) @(negedge clk_i);
		acc = 0;
		d0 = 0;
		for (int i = 0; i < 320; i++) begin
			@(negedge link_clk_i);
			if (tx_sync_clock_out_o === 1'b1 && pv === 1'b0) acc++;
			if (rx_sync_clock_out_o === 1'b1 && pr === 1'b0) d0++;
			pv = tx_sync_clock_out_o;
			pr = rx_sync_clock_out_o;
		end
		chk("tx sync clock rate", 1, acc >= exp_rises(320) - 1 && acc <= exp_rises(320) + 1);
		chk("rx sync clock rate", 1, d0 >= exp_rises(320) - 1 && d0 <= exp_rises(320) + 1);
		// one byte in sync mode: launched on the falling clock, read on the rising one
		@(negedge clk_i);
		wr_data_i = 8'ha6;
		wr_valid_i = 1'b1;
		@(negedge clk_i);
		wr_valid_i = 1'b0;
		for (int i = 0; i < 400 && rxd_o !== 1'b0; i++) @(posedge tx_sync_clock_out_o);
		b = 8'h00;
		for (int i = 1; i < 8; i++) begin
			@(posedge tx_sync_clock_out_o);
			b[i] = rxd_o;
		end
		chk("sync tx byte", 8'ha6, b);
		tally_and_finish();
	end
endmodule : modem_host_serial_interface_test
`default_nettype wire
